// File: swuart_slave.v
// Single-wire UART slave: receives datagrams, answers reads, counts accepted writes.
// Assumes a synchronous serial line input and a register source outside this block.
`timescale 1ns/1ns
`include "swuart_regs.vh"
module swuart_slave (
	// Clock and reset.
	input wire clock,
	input wire rst,
	// Serial line pin as three signals.
	input wire serial_line_pin_in,
	output reg serial_line_pin_out,
	output reg serial_line_pin_oe,
	// Address straps.
	input wire addr_strap_lsb,
	input wire addr_strap_msb,
	// Reply delay setting.
	input wire [3:0] reply_delay_setting,
	// Register read port.
	output reg [6:0] rd_addr,
	input wire [31:0] rd_data,
	// Accepted write.
	output reg wr_strobe,
	output reg [6:0] wr_addr,
	output reg [31:0] wr_data,
	output reg [7:0] datagram_count
);
	localparam S_IDLE = 3'h0;
	localparam S_SYNC = 3'h1;
	localparam S_RX = 3'h2;
	localparam S_DELAY = 3'h3;
	localparam S_TX = 3'h4;
	localparam S_HOLD = 3'h5;
	reg [2:0] state;
	reg [`CNT_W-1:0] bit_time;
	reg [`CNT_W-1:0] cnt;
	reg [`CNT_W-1:0] gap;
	reg [`CNT_W-1:0] tmr;
	reg [3:0] bitn;
	reg [3:0] byten;
	reg [7:0] rx_sh;
	reg [7:0] tx_sh;
	reg [7:0] crc;
	reg [7:0] abyte;
	reg [7:0] rbyte;
	reg [31:0] dword;
	reg [7:0] delay_bits;
	reg prev_line;
	reg [7:0] tx_byte;
	reg [7:0] crc_src;
	reg [7:0] crc_data;
	wire [1:0] node_address = {addr_strap_msb, addr_strap_lsb};
	wire fall = prev_line & ~serial_line_pin_in;
	wire [7:0] crc_next;
	wire [`CNT_W-1:0] half = {1'b0, bit_time[`CNT_W-1:1]};
	wire [`CNT_W-1:0] cnt_inc = cnt + 1'b1;
	wire own_node = (abyte == {6'h00, node_address});
	wire crc_good = (crc == rx_sh);
	wire is_write = rbyte[`RW_BIT];
	function [`CNT_W-1:0] bits_to_cycles;
		input [`CNT_W-1:0] bt;
		input [7:0] n;
		bits_to_cycles = bt * n;
	endfunction
	function [7:0] reply_byte;
		input [3:0] idx;
		input [6:0] addr;
		input [31:0] word;
		input [7:0] sum;
		case (idx)
			4'h0: reply_byte = {4'h0, `SYNC_NIBBLE};
			4'h1: reply_byte = `MASTER_ADDR;
			4'h2: reply_byte = {1'b0, addr};
			4'h3: reply_byte = word[31:24];
			4'h4: reply_byte = word[23:16];
			4'h5: reply_byte = word[15:8];
			4'h6: reply_byte = word[7:0];
			default: reply_byte = sum;
		endcase
	endfunction
	// ==========
	// CRC source selection.
	always @* begin
		tx_byte = reply_byte(byten, rd_addr, dword, crc);
		crc_src = crc;
		crc_data = rx_sh;
		if (state == S_SYNC) begin
			crc_src = 8'h00;
			crc_data = `SYNC_BYTE;
		end else if (state == S_TX) begin
			crc_data = tx_byte;
		end
	end
	crc8_byte crc8_byte_i (
		.crc_in(crc_src),
		.data(crc_data),
		.crc_out(crc_next)
	);
	// ==========
	// Receive, delay, transmit and release.
	always @(posedge clock) begin
		if (rst) begin
			state <= S_IDLE;
			bit_time <= {`CNT_W{1'b0}};
			cnt <= {`CNT_W{1'b0}};
			gap <= {`CNT_W{1'b0}};
			tmr <= {`CNT_W{1'b0}};
			bitn <= 4'h0;
			byten <= 4'h0;
			rx_sh <= 8'h00;
			tx_sh <= 8'h00;
			crc <= 8'h00;
			abyte <= 8'h00;
			rbyte <= 8'h00;
			dword <= 32'h0000_0000;
			delay_bits <= 8'h00;
			prev_line <= 1'b1;
			serial_line_pin_out <= 1'b1;
			serial_line_pin_oe <= 1'b0;
			rd_addr <= 7'h00;
			wr_strobe <= 1'b0;
			wr_addr <= 7'h00;
			wr_data <= 32'h0000_0000;
			datagram_count <= 8'h00;
		end else begin
			prev_line <= serial_line_pin_in;
			wr_strobe <= 1'b0;
			cnt <= cnt_inc;
			gap <= gap + 1'b1;
			if (tmr != {`CNT_W{1'b0}}) begin
				tmr <= tmr - 1'b1;
			end
			case (state)
				S_IDLE: begin
					if (fall) begin
						cnt <= {`CNT_W{1'b0}};
						bitn <= 4'h0;
						state <= S_SYNC;
					end
				end
				S_SYNC: begin
					if (fall) begin
						bitn <= bitn + 1'b1;
						if (bitn == 4'h1) begin
							// Start edge to the edge between sync bits 2 and 3 spans four bits.
							bit_time <= {2'h0, cnt_inc[`CNT_W-1:2]};
							crc <= crc_next;
							gap <= cnt;
							bitn <= 4'h0;
							byten <= 4'h1;
							state <= S_RX;
						end
					end
				end
				S_RX: begin
					if (gap > bits_to_cycles(bit_time, `TIMEOUT_BITS)) begin
						state <= S_IDLE;
					end else if (bitn == 4'h0) begin
						if (fall) begin
							gap <= {`CNT_W{1'b0}};
							tmr <= bit_time + half - 1'b1;
							bitn <= 4'h1;
						end
					end else if (tmr == {`CNT_W{1'b0}}) begin
						tmr <= bit_time - 1'b1;
						bitn <= bitn + 1'b1;
						if (bitn != `BYTE_BITS - 1'b1) begin
							rx_sh <= {serial_line_pin_in, rx_sh[7:1]};
						end else begin
							bitn <= 4'h0;
							byten <= byten + 1'b1;
							crc <= crc_next;
							if (byten == 4'h1) begin
								abyte <= rx_sh;
							end
							if (byten == 4'h2) begin
								rbyte <= rx_sh;
							end
							if (byten >= 4'h3 && byten <= 4'h6) begin
								dword <= {dword[23:0], rx_sh};
							end
							if (byten == `REQ_BYTES - 1'b1 && !is_write) begin
								state <= S_IDLE;
								if (crc_good && own_node) begin
									rd_addr <= rbyte[6:0];
									delay_bits <= `DELAY_STEP_BITS * ((reply_delay_setting == 4'h0) ?
										8'h01 : {4'h0, reply_delay_setting});
									cnt <= {`CNT_W{1'b0}};
									state <= S_DELAY;
								end
							end else if (byten == `WR_BYTES - 1'b1) begin
								state <= S_IDLE;
								if (crc_good && own_node) begin
									wr_strobe <= 1'b1;
									wr_addr <= rbyte[6:0];
									wr_data <= dword;
									datagram_count <= datagram_count + 1'b1;
								end
							end
						end
					end
				end
				S_DELAY: begin
					// The delay runs from the end of the request stop bit.
					if (cnt == bits_to_cycles(bit_time, delay_bits) + half - 1'b1) begin
						dword <= rd_data;
						crc <= 8'h00;
						byten <= 4'h0;
						bitn <= 4'h0;
						tmr <= {`CNT_W{1'b0}};
						serial_line_pin_out <= 1'b1;
						serial_line_pin_oe <= 1'b1;
						state <= S_TX;
					end
				end
				S_TX: begin
					if (tmr == {`CNT_W{1'b0}}) begin
						tmr <= bit_time - 1'b1;
						bitn <= bitn + 1'b1;
						if (bitn == 4'h0) begin
							serial_line_pin_out <= 1'b0;
							tx_sh <= tx_byte;
							crc <= crc_next;
						end else if (bitn != `BYTE_BITS - 1'b1) begin
							serial_line_pin_out <= tx_sh[0];
							tx_sh <= {1'b0, tx_sh[7:1]};
						end else begin
							serial_line_pin_out <= 1'b1;
							bitn <= 4'h0;
							byten <= byten + 1'b1;
							if (byten == `REPLY_BYTES - 1'b1) begin
								cnt <= {`CNT_W{1'b0}};
								state <= S_HOLD;
							end
						end
					end
				end
				S_HOLD: begin
					// The final stop bit plus the turn-off time.
					if (cnt == bits_to_cycles(bit_time, {4'h0, `TURNOFF_BITS} + 8'h01) - 1'b1) begin
						serial_line_pin_oe <= 1'b0;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule

// File: swuart_regs.vh
// Constants for the single-wire UART slave: datagram fields, CRC and timing counts.
// Assumes inclusion by the UART slave modules only.
`ifndef SWUART_REGS_VH
`define SWUART_REGS_VH
`define SYNC_NIBBLE 4'h5
`define SYNC_BYTE 8'h05
`define MASTER_ADDR 8'hFF
`define CRC_POLY_LOW 8'h07
`define RW_BIT 7
`define REQ_BYTES 4'h4
`define WR_BYTES 4'h8
`define REPLY_BYTES 4'h8
`define BYTE_BITS 4'hA
`define TURNOFF_BITS 4'h4
`define DELAY_STEP_BITS 8'h08
`define DELAY_DEFAULT 4'h0
`define TIMEOUT_BITS 8'h3F
`define CNT_W 20
`endif

// File: crc8_byte.v
// Byte-wide CRC-8 update, bits taken LSB first.
// Assumes the caller holds the CRC register and presents one byte at a time.
`timescale 1ns/1ns
`include "swuart_regs.vh"
module crc8_byte (
	// Inputs.
	input wire [7:0] crc_in,
	input wire [7:0] data,
	// Result.
	output reg [7:0] crc_out
);
	integer i;
	reg [7:0] c;
	always @* begin
		c = crc_in;
		for (i = 0; i < 8; i = i + 1) begin
			if (c[7] ^ data[i]) begin
				c = {c[6:0], 1'b0} ^ `CRC_POLY_LOW;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc_out = c;
	end
endmodule

// File: uart_host.sv
// Host UART model on the shared wire: sends framed bytes with CRC, receives bytes.
// Assumes an idle-high wired-AND line and a bit time of BT clock cycles.
`timescale 1ns/1ns
module uart_host #(parameter int BT = 16) (
	// Clock and line.
	input wire clock,
	input wire line,
	output logic drive
);
	// ==========
	// Transfers.
	initial drive = 1'b1;
	function automatic logic [7:0] crc(input logic [7:0] q[$]);
		logic [7:0] c;
		c = 8'h00;
		foreach (q[i]) for (int j = 0; j < 8; j++)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i][j]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	task automatic tx(input logic [7:0] q[$], input logic [7:0] flip);
		logic [9:0] f;
		q.push_back(crc(q) ^ flip);
		@(negedge clock);
		foreach (q[k]) begin
			f = {1'b1, q[k], 1'b0};
			for (int i = 0; i < 10; i++) begin
				drive = f[i];
				repeat (BT) @(negedge clock);
			end
		end
	endtask
	task automatic rx(output logic [7:0] b, output int n);
		for (n = 0; n < 3000 && line; n++) @(negedge clock);
		repeat (BT / 2) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BT) @(negedge clock);
			b[i] = line;
		end
		repeat (BT) @(negedge clock);
	endtask
endmodule

// File: swuart_slave_assertions.sv
// Concurrent checks on the UART slave ports.
// Assumes one clock domain and the synchronous reset rst.
`timescale 1ns/1ns
module swuart_slave_assertions (
	// Watched ports.
	input wire clock,
	input wire rst,
	input wire serial_line_pin_in,
	input wire serial_line_pin_out,
	input wire serial_line_pin_oe,
	input wire [6:0] rd_addr,
	input wire wr_strobe,
	input wire [7:0] datagram_count
);
	// ==========
	// Checks.
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_reset_quiet:
	assert property ($fell(rst) |-> !serial_line_pin_oe && datagram_count == 8'h00)
		else $error("reset state wrong");
	a_count_step:
	assert property ($changed(datagram_count) && !$past(rst) |->
		datagram_count == $past(datagram_count) + 8'h01) else $error("count step wrong");
	a_strobe_pulse:
	assert property (wr_strobe |=> !wr_strobe) else $error("strobe too long");
	a_write_silent:
	assert property (wr_strobe |-> !serial_line_pin_oe) else $error("drive on write");
	a_idle_first:
	assert property ($rose(serial_line_pin_oe) |-> $past(serial_line_pin_in))
		else $error("drive over busy line");
	a_addr_held:
	assert property (serial_line_pin_oe && $past(serial_line_pin_oe) |-> $stable(rd_addr))
		else $error("read address moved");
	a_tail_high:
	assert property ($fell(serial_line_pin_oe) |->
		$past(serial_line_pin_out) && $past(serial_line_pin_out, 8)) else $error("tail low");
	a_reply_long:
	assert property ($rose(serial_line_pin_oe) |=> serial_line_pin_oe [*8])
		else $error("reply too short");
	c_write: cover property ($rose(wr_strobe));
	c_reply: cover property ($fell(serial_line_pin_oe));
	c_count: cover property ($changed(datagram_count));
endmodule
bind swuart_slave swuart_slave_assertions swuart_slave_assertions_i (.clock, .rst,
	.serial_line_pin_in, .serial_line_pin_out, .serial_line_pin_oe, .rd_addr,
	.wr_strobe, .datagram_count);

// File: single_wire_uart_read_crc_test.sv
// Self-checking bench for the UART slave: reads, writes, bad CRC, foreign node.
// Assumes the host model drives the shared line with a bit time of BT cycles.
`timescale 1ns/1ns
module single_wire_uart_read_crc_test;
	// ==========
	// Bench.
	localparam int BT = 16;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic lsb = 1'b1;
	logic msb = 1'b0;
	logic [3:0] dly = 4'h2;
	logic [31:0] rdat;
	wire line, hd, out, oe, stb;
	wire [6:0] ra, wa;
	wire [31:0] wd;
	wire [7:0] cnt;
	int bad_count = 0;
	int n_compared = 0;
	assign line = hd & (oe ? out : 1'b1);
	assign rdat = {1'b0, ra, 8'hC3, 1'b1, ra, 8'h5A};
	initial forever #5 clock = ~clock;
	uart_host #(.BT(BT)) uart_host_i (.clock(clock), .line(line), .drive(hd));
	swuart_slave swuart_slave_i (.clock(clock), .rst(rst), .serial_line_pin_in(line),
		.serial_line_pin_out(out), .serial_line_pin_oe(oe), .addr_strap_lsb(lsb),
		.addr_strap_msb(msb), .reply_delay_setting(dly), .rd_addr(ra), .rd_data(rdat),
		.wr_strobe(stb), .wr_addr(wa), .wr_data(wd), .datagram_count(cnt));
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic end_sim;
		if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_read(input logic [6:0] a, input logic [7:0] node, input logic own);
		logic [7:0] e[$], b, c0;
		int n, d;
		repeat (16 * BT) @(negedge clock);
		c0 = cnt;
		d = 8 * (dly == 4'h0 ? 1 : dly) * BT;
		uart_host_i.tx('{8'h05, node, {1'b0, a}}, 8'h00);
		e = '{8'h05, 8'hFF, {1'b0, a}, {1'b0, a}, 8'hC3, {1'b1, a}, 8'h5A};
		e.push_back(uart_host_i.crc(e));
		uart_host_i.rx(b, n);
		if (!own) chk(n == 3000, "reply to foreign request");
		else begin
			chk(n > d - BT && n < d + BT, "reply delay");
			if (n == 3000) end_sim;
			foreach (e[k]) begin
				if (k > 0) uart_host_i.rx(b, n);
				chk(b === e[k], "reply byte");
			end
			chk(ra === a, "read address");
			repeat (3 * BT) @(negedge clock);
			chk(oe === 1'b1, "driver dropped early");
			repeat (2 * BT) @(negedge clock);
			chk(oe === 1'b0, "driver held too long");
		end
		chk(cnt === c0, "count moved on read");
	endtask
	task automatic t_write(input logic [6:0] a, input logic [7:0] node, flip, input logic ok);
		logic [7:0] c0;
		int n;
		repeat (16 * BT) @(negedge clock);
		c0 = cnt;
		fork
			uart_host_i.tx('{8'h05, node, {1'b1, a}, 8'hDE, 8'hAD, {1'b0, a}, 8'h3C}, flip);
			for (n = 0; n < 2000 && stb !== 1'b1; n++) @(negedge clock);
		join
		if (ok) begin
			chk(n < 2000 && wa === a && wd === {16'hDEAD, 1'b0, a, 8'h3C}, "write");
			repeat (2) @(negedge clock);
			chk(cnt === c0 + 8'h01, "count step");
		end else chk(n == 2000 && cnt === c0, "bad write taken");
	endtask
	initial begin
		repeat (6) @(negedge clock);
		rst = 1'b0;
		t_read(7'h15, 8'h01, 1'b1);
		t_write(7'h22, 8'h01, 8'h00, 1'b1);
		t_write(7'h22, 8'h01, 8'h40, 1'b0);
		t_read(7'h15, 8'h03, 1'b0);
		t_read(7'h15, 8'hFF, 1'b0);
		{msb, lsb} = 2'b10;
		dly = 4'h0;
		t_read(7'h6A, 8'h02, 1'b1);
		t_write(7'h7F, 8'h02, 8'h00, 1'b1);
		end_sim;
	end
	initial begin
		#1000000;
		chk(1'b0, "timeout");
		end_sim;
	end
endmodule
